// *** include/dit_consts.vh ***
// Constants for the debug integration and claim-tag block.
// Assumes inclusion by bare name from rtl files; definitions only.
`ifndef DIT_CONSTS_VH
`define DIT_CONSTS_VH

`define DIT_ADDR_W          8
`define DIT_ADR_OUT_DRIVE   8'h00
`define DIT_ADR_IN_SAMPLE   8'h04
`define DIT_ADR_MODE_CTRL   8'h08
`define DIT_ADR_CLAIM_SET   8'h0c
`define DIT_ADR_CLAIM_CLR   8'h10

`define DIT_BIT_MODE_EN     0
`define DIT_BIT_IN_EDBG     0
`define DIT_BIT_IN_IRQ      1
`define DIT_BIT_IN_FIQ      2
`define DIT_BIT_OUT_ACK     0
`define DIT_BIT_OUT_PMU     4
`define DIT_BIT_OUT_RESTART 9

`define DIT_CLAIM_W         8
`define DIT_CLAIM_RESET     8'h00
`define DIT_CLAIM_RAO       8'hff
`define DIT_OUT_RESET       32'h0000_0010
`define DIT_OUT_MASK        32'h0000_0211
`define DIT_MODE_RESET      32'h0000_0000
`define DIT_MODE_MASK       32'h0000_0001

`endif

// *** rtl/dit_claim_tags.v ***
// Eight claim-tag bits with write-one-to-set and write-one-to-clear ports.
// Assumes one-cycle write pulses synchronous to clk.
`timescale 1ns/1ps
`include "dit_consts.vh"

module dit_claim_tags (
	input  wire                    clk,
	input  wire                    rst,
	input  wire                    set_we,
	input  wire                    clr_we,
	input  wire [`DIT_CLAIM_W-1:0] wdata,
	output reg  [`DIT_CLAIM_W-1:0] tags
);

	always @(posedge clk) begin
		if (rst) begin
			tags <= `DIT_CLAIM_RESET; // R10
		end else if (set_we) begin
			tags <= tags | wdata; // R5 R6
		end else if (clr_we) begin
			tags <= tags & ~wdata; // R9
		end
	end

endmodule // dit_claim_tags

// *** rtl/dit_pin_mux.v ***
// Output pin multiplexer: functional logic or integration drive values.
// Assumes functional inputs are synchronous to clk; outputs are registered.
`timescale 1ns/1ps

module dit_pin_mux (
	input  wire clk,
	input  wire rst,
	input  wire mode_en,
	input  wire func_dbg_ack,
	input  wire func_pmu_irq,
	input  wire func_restart,
	input  wire it_dbg_ack,
	input  wire it_pmu_irq,
	input  wire it_restart,
	output reg  debug_acknowledge_out,
	output reg  perf_monitor_interrupt,
	output reg  debug_restart_done
);

	always @(posedge clk) begin
		if (rst) begin
			debug_acknowledge_out  <= 1'b0;
			perf_monitor_interrupt <= 1'b0;
			debug_restart_done     <= 1'b0;
		end else if (mode_en) begin
			debug_acknowledge_out  <= it_dbg_ack; // R4 R11
			perf_monitor_interrupt <= it_pmu_irq; // R11
			debug_restart_done     <= it_restart; // R11
		end else begin
			debug_acknowledge_out  <= func_dbg_ack; // R12
			perf_monitor_interrupt <= func_pmu_irq; // R12
			debug_restart_done     <= func_restart; // R12
		end
	end

endmodule // dit_pin_mux

// *** rtl/dit_debug_integration.v ***
// Debug integration-test controls and claim tags behind a classic Wishbone slave.
// Assumes pins synchronous to clk and a single-cycle classic Wishbone master.
//
// Notes on behaviour
// R1 - Input sample register shows fast irq bit2, irq bit1, debug request bit0.
// R2 - Mode control bit 0 set selects integration mode; clear is normal.
// R3 - Mode control is unreachable from the coprocessor port; only Wishbone reaches it.
// R4 - In integration mode software drives outputs and samples inputs via registers.
// R5 - Writing ones to claim-set sets those tags; claim-set reads all ones.
// R6 - One claim-set write may set several tags together.
// R7 - Claim tags affect no other function; pure software storage.
// R8 - Debuggers and monitors set claim bits to announce ownership.
// R9 - Claim-clear write clears bits written one; reads return current tags.
// R10 - Reset clears all eight claim tags.
// R11 - Output drive register reaches pins only while mode bit 0 is set.
// R12 - With mode clear, pins return to functional logic.
`timescale 1ns/1ps
`include "dit_consts.vh"

module dit_debug_integration (
	input  wire        clk,
	input  wire        rst,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         wb_err_o,
	input  wire        fast_int_req_n,
	input  wire        int_req_n,
	input  wire        ext_debug_request,
	input  wire        func_dbg_ack,
	input  wire        func_pmu_irq,
	input  wire        func_restart,
	output wire        debug_acknowledge_out,
	output wire        perf_monitor_interrupt,
	output wire        debug_restart_done,
	output reg         integration_mode,
	output reg  [7:0]  claim_tags_out
);

	reg  [31:0] integration_output_drive;
	reg  [31:0] integration_mode_control;
	wire [7:0]  claim_tags;
	wire        req;
	wire        hit_out;
	wire        hit_in;
	wire        hit_mode;
	wire        hit_set;
	wire        hit_clr;
	wire        mapped;
	wire        wr;
	wire [31:0] in_sample;
	reg  [31:0] next_rdata;

	// Byte-enable merge used by the mode control and output drive registers
	function [31:0] merge_bytes;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  sel;
		integer k;
		begin
			merge_bytes = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (sel[k]) begin
					merge_bytes[k*8 +: 8] = nw[k*8 +: 8];
				end
			end
		end
	endfunction

	assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign hit_out  = (wb_adr_i == `DIT_ADR_OUT_DRIVE);
	assign hit_in   = (wb_adr_i == `DIT_ADR_IN_SAMPLE);
	assign hit_mode = (wb_adr_i == `DIT_ADR_MODE_CTRL); // R3
	assign hit_set  = (wb_adr_i == `DIT_ADR_CLAIM_SET);
	assign hit_clr  = (wb_adr_i == `DIT_ADR_CLAIM_CLR);
	assign mapped   = hit_out | hit_in | hit_mode | hit_set | hit_clr;
	assign wr       = req & wb_we_i & mapped;

	// Live pin levels, reserved bits zero
	assign in_sample = {29'h0000_0000, fast_int_req_n, int_req_n, ext_debug_request}; // R1

	always @* begin
		next_rdata = 32'h0000_0000;
		if (hit_out) begin
			next_rdata = integration_output_drive;
		end else if (hit_in) begin
			next_rdata = in_sample; // R1
		end else if (hit_mode) begin
			next_rdata = integration_mode_control;
		end else if (hit_set) begin
			next_rdata = {24'h00_0000, `DIT_CLAIM_RAO}; // R5
		end else if (hit_clr) begin
			next_rdata = {24'h00_0000, claim_tags}; // R9
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req & mapped;
			wb_err_o <= req & ~mapped;
			if (req & ~wb_we_i & mapped) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			integration_mode_control <= `DIT_MODE_RESET;
			integration_output_drive <= `DIT_OUT_RESET;
			integration_mode         <= 1'b0;
			claim_tags_out           <= `DIT_CLAIM_RESET;
		end else begin
			if (wr & hit_mode) begin
				integration_mode_control <= merge_bytes(integration_mode_control,
					wb_dat_i, wb_sel_i) & `DIT_MODE_MASK; // R2
			end
			if (wr & hit_out) begin
				integration_output_drive <= merge_bytes(integration_output_drive,
					wb_dat_i, wb_sel_i) & `DIT_OUT_MASK; // R4
			end
			integration_mode <= integration_mode_control[`DIT_BIT_MODE_EN]; // R2
			claim_tags_out   <= claim_tags; // R7
		end
	end

	dit_claim_tags u_claim (
		.clk    (clk),
		.rst    (rst),
		.set_we (wr & hit_set & wb_sel_i[0]), // R5 R6
		.clr_we (wr & hit_clr & wb_sel_i[0]), // R9
		.wdata  (wb_dat_i[7:0]),
		.tags   (claim_tags)
	);

	dit_pin_mux u_mux (
		.clk                    (clk),
		.rst                    (rst),
		.mode_en                (integration_mode_control[`DIT_BIT_MODE_EN]), // R11
		.func_dbg_ack           (func_dbg_ack),
		.func_pmu_irq           (func_pmu_irq),
		.func_restart           (func_restart),
		.it_dbg_ack             (integration_output_drive[`DIT_BIT_OUT_ACK]),
		.it_pmu_irq             (integration_output_drive[`DIT_BIT_OUT_PMU]),
		.it_restart             (integration_output_drive[`DIT_BIT_OUT_RESTART]),
		.debug_acknowledge_out  (debug_acknowledge_out),
		.perf_monitor_interrupt (perf_monitor_interrupt),
		.debug_restart_done     (debug_restart_done)
	);

endmodule // dit_debug_integration

// *** verif/dit_checker_assertions.sv ***
// Concurrent checks on the debug integration block's top-level ports.
// Assumes a single classic Wishbone master; claim and mode writes act only with sel bit 0.
`timescale 1ns/1ps
module dit_checker (
	input wire        clk,
	input wire        rst,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        wb_err_o,
	input wire        fast_int_req_n,
	input wire        int_req_n,
	input wire        ext_debug_request,
	input wire        func_dbg_ack,
	input wire        func_pmu_irq,
	input wire        func_restart,
	input wire        debug_acknowledge_out,
	input wire        perf_monitor_interrupt,
	input wire        debug_restart_done,
	input wire        integration_mode,
	input wire [7:0]  claim_tags_out
);
	wire       rq = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
	wire       w  = rq & wb_we_i;
	wire       r  = rq & !wb_we_i;
	wire [7:0] a  = wb_adr_i;
	wire       m  = a == 8'h00 || a == 8'h04 || a == 8'h08 || a == 8'h0c || a == 8'h10;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	in_sample_a: assert property (r && a == 8'h04 |=> wb_dat_o == {29'h0,
		$past(fast_int_req_n), $past(int_req_n), $past(ext_debug_request)}) else $error("sample");
	mode_bit_a: assert property (w && a == 8'h08 && wb_sel_i[0] |->
		##2 integration_mode == $past(wb_dat_i[0], 2)) else $error("mode");
	set_read_a: assert property (r && a == 8'h0c |=> wb_dat_o == 32'hff)
		else $error("set read");
	claim_set_a: assert property (w && a == 8'h0c && wb_sel_i[0] |-> ##2
		claim_tags_out == ($past(claim_tags_out) | $past(wb_dat_i[7:0], 2))) else $error("set");
	claim_clr_a: assert property (w && a == 8'h10 && wb_sel_i[0] |-> ##2
		claim_tags_out == ($past(claim_tags_out) & ~$past(wb_dat_i[7:0], 2))) else $error("clr");
	clr_read_a: assert property (r && a == 8'h10 |=> wb_dat_o == {24'h0, claim_tags_out})
		else $error("clr read");
	tag_reset_a: assert property ($fell(rst) |-> claim_tags_out == 8'h00)
		else $error("reset");
	func_pins_a: assert property (!integration_mode && !$past(rst) |->
		{debug_restart_done, perf_monitor_interrupt, debug_acknowledge_out} ==
		{$past(func_restart), $past(func_pmu_irq), $past(func_dbg_ack)}) else $error("pins");
	claim_hold_a: assert property (w && (a == 8'h0c || a == 8'h10) && !wb_sel_i[0] |->
		##2 $stable(claim_tags_out)) else $error("lane");
	bus_answer_a: assert property (rq |=> wb_ack_o == $past(m) && wb_err_o == !$past(m))
		else $error("answer");
endmodule // dit_checker

bind dit_debug_integration dit_checker dit_checker_inst (.*);

// *** verif/dit_host.sv ***
// Wishbone master standing for debug software on the register side.
// Assumes the block answers every request with ack or err.
`timescale 1ns/1ps
module dit_host (
	input  wire        clk,
	input  wire        wb_ack_o,
	input  wire        wb_err_o,
	input  wire [31:0] wb_dat_o,
	output logic       wb_cyc_i = 0,
	output logic       wb_we_i = 0,
	output logic [7:0] wb_adr_i = 0,
	output logic [31:0] wb_dat_i = 0
);
	task xfer(input bit w, input [7:0] ad, input [31:0] d, output [31:0] q);
		wb_cyc_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= ad;
		wb_dat_i <= d;
		do @(posedge clk); while (!(wb_ack_o | wb_err_o));
		q = wb_dat_o;
		wb_cyc_i <= 0;
		@(posedge clk);
	endtask
endmodule // dit_host

// *** verif/dit_debug_integration_tb.sv ***
// Self-checking bench for the debug integration and claim-tag block.
// Assumes the host model owns the Wishbone strobes; the bench drives sel and the pins.
`timescale 1ns/1ps
module dit_debug_integration_tb;
	logic        clk, rst;
	logic        fast_int_req_n = 1, int_req_n = 1, ext_debug_request = 0;
	logic        func_dbg_ack = 0, func_pmu_irq = 1, func_restart = 0;
	wire         wb_cyc_i, wb_we_i, wb_ack_o, wb_err_o, integration_mode;
	wire         debug_acknowledge_out, perf_monitor_interrupt, debug_restart_done;
	wire  [7:0]  wb_adr_i, claim_tags_out;
	wire  [31:0] wb_dat_i, wb_dat_o;
	wire         wb_stb_i = wb_cyc_i;
	logic [3:0]  wb_sel_i = 4'hf;
	wire  [2:0]  pins = {debug_restart_done, perf_monitor_interrupt, debug_acknowledge_out};
	int          error_cnt = 0, total_checks = 0;
	logic [31:0] q;
	logic [72:0] rows [13] = '{{1'b0,8'h0c,32'h0,32'hff}, {1'b0,8'h10,32'h0,32'h0},
		{1'b1,8'h0c,32'ha5,32'h0}, {1'b0,8'h10,32'h0,32'ha5}, {1'b1,8'h0c,32'h42,32'h0},
		{1'b1,8'h10,32'h81,32'h0}, {1'b0,8'h10,32'h0,32'h66}, {1'b0,8'h04,32'h0,32'h6},
		{1'b1,8'h08,32'hffffffff,32'h0}, {1'b0,8'h08,32'h0,32'h1},
		{1'b1,8'h00,32'hffffffff,32'h0}, {1'b0,8'h00,32'h0,32'h211},
		{1'b0,8'h14,32'h0,32'h211}};
	dit_debug_integration dit_debug_integration_inst (.*);
	dit_host dit_host_inst (.*);
	task check(input [31:0] s, input [31:0] e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#50000;
		error_cnt++;
		summarize;
	end
	initial begin
		rst = 1;
		repeat (16) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		foreach (rows[i]) begin
			dit_host_inst.xfer(rows[i][72], rows[i][71:64], rows[i][63:32], q);
			if (!rows[i][72])
				check(q, rows[i][31:0]);
		end
		@(negedge clk);
		check(32'(pins), 32'h7);
		$display("register rows done");
		@(posedge clk);
		dit_host_inst.xfer(1, 8'h08, 32'h0, q);
		@(negedge clk);
		check(32'(pins), 32'h2);
		$display("pin source done");
		@(posedge clk);
		fast_int_req_n <= 0;
		ext_debug_request <= 1;
		func_dbg_ack <= 1;
		func_pmu_irq <= 0;
		func_restart <= 1;
		dit_host_inst.xfer(0, 8'h04, 32'h0, q);
		check(q, 32'h3);
		@(negedge clk);
		check(32'(pins), 32'h5);
		$display("live pins done");
		@(posedge clk);
		wb_sel_i <= 4'he;
		dit_host_inst.xfer(1, 8'h0c, 32'hff, q);
		wb_sel_i <= 4'hf;
		dit_host_inst.xfer(0, 8'h10, 32'h0, q);
		check(q, 32'h66);
		$display("byte lanes done");
		@(posedge clk);
		rst <= 1;
		repeat (3) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		dit_host_inst.xfer(0, 8'h10, 32'h0, q);
		check(q, 32'h0);
		$display("second reset done");
		summarize;
	end
endmodule // dit_debug_integration_tb
